// ### src/fbi_defs.vh
`ifndef FBI_DEFS_VH
`define FBI_DEFS_VH
`define FBI_ADDR_W 23
`define FBI_DATA_W 16
`define FBI_BANK_HI 22
`define FBI_BANK_LO 20
`define FBI_PAGE_LO 3
`define FBI_CLK_MHZ 20
`define FBI_T_ADDR_NS 65
`define FBI_T_SEL_NS 65
`define FBI_T_PAGE_NS 25
`define FBI_T_SETUP_NS 50
`define FBI_T_WPULSE_NS 50
`define FBI_T_RESET_NS 500
`define FBI_T_RECOVER_NS 200
`define FBI_CYC(ns) (((ns) * `FBI_CLK_MHZ + 999) / 1000)
`define FBI_OP_READ 2'h0
`define FBI_OP_WRITE 2'h1
`define FBI_OP_RESET 2'h2
`define FBI_BANK_A 3'h0
`define FBI_BANK_B 3'h1
`define FBI_BANK_C 3'h2
`define FBI_BANK_D 3'h3
`define FBI_BANK_1A 3'h4
`define FBI_BANK_1B 3'h5
`define FBI_BANK_2A 3'h6
`define FBI_BANK_2B 3'h7
`endif

// ### src/fbi_page_reg.v
`timescale 1ns/1ps
`default_nettype none
module fbi_page_reg (
    input wire clock_in,
    input wire reset_in,
    input wire write_in,
    input wire [2:0] word_in,
    input wire [15:0] data_in,
    input wire [2:0] read_word_in,
    output reg [15:0] data_out
);
    reg [15:0] words [0:7];
    integer i;
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            for (i = 0; i < 8; i = i + 1) begin
                words[i] <= 16'h0000;
            end
            data_out <= 16'h0000;
        end else begin
            if (write_in) begin
                words[word_in] <= data_in;
            end
            data_out <= words[read_word_in];
        end
    end
endmodule // fbi_page_reg
`default_nettype wire

// ### src/fbi_host.v
// Function
// [R01] Reads drive output gate and select low, write strobe held high.
// [R02] Dual-select part: lower select covers low half, upper select high half.
// [R03] Device starts in read-array state after power-up or hardware reset.
// [R04] Banks stay in read-array until a command write changes them.
// [R05] Upper address picks an 8-word page; low three bits pick the word.
// [R06] First page access waits full delay; in-page accesses wait short delay.
// [R07] After all selects go high, next access uses the full delay.
// [R08] Reads may target one bank while another bank programs or erases.
// [R09] Single-select bank decode: 000 A, 001-011 B, 100-110 C, 111 D.
// [R10] Dual-select decode: low 00-10 1A, 11 1B; high 00 2A, else 2B.
// [R11] Command writes drive strobe and one select low, output gate high.
// [R12] Two-cycle program mode programs a word in two writes.
// [R13] Erase covers one sector, several sectors or whole device.
// [R14] High voltage on boost pin gives two-cycle mode and unprotects sectors.
// [R15] Boost voltage only for accelerated programming; else pin driven high.
// [R16] Boost low keeps boot sectors protected; high follows stored state.
// [R17] Never assert a flash select with both RAM selects active.
// [R18] Identification reads return internal codes on sixteen lines, normal timing.
// [R19] All selects and reset high means standby, outputs floating.
// [R20] First read after standby waits full select-to-data delay.
// [R21] Deselecting during program or erase does not abort it.
// [R22] Reset low ends operations, floats outputs, ignores cycles.
// [R23] Ready/busy stays low until internal reset completes.
// [R24] Output gate high floats all outputs except ready/busy.
// [R25] Write captured by later falling and earlier rising strobe/select edge.
`timescale 1ns/1ps
`default_nettype none
`include "fbi_defs.vh"
module fbi_host (
    input wire clock_in,
    input wire reset_in,
    input wire req_valid_in,
    input wire [1:0] req_op_in,
    input wire [22:0] req_addr_in,
    input wire [15:0] req_data_in,
    input wire dual_select_in,
    input wire boost_fast_in,
    input wire boost_protect_in,
    output reg req_ready_out,
    output reg resp_valid_out,
    output reg [15:0] resp_data_out,
    output reg [2:0] resp_bank_out,
    output reg busy_seen_out,
    output reg [22:0] addr_out,
    output reg [15:0] data_out,
    output reg data_oe_out,
    input wire [15:0] data_in,
    output reg lower_half_select_n_out,
    output reg upper_half_select_n_out,
    output reg output_gate_n_out,
    output reg write_strobe_n_out,
    output reg hw_reset_n_out,
    output reg ram_select1_n_out,
    output reg ram_select2_out,
    output reg boost_high_out,
    output reg boost_fast_out,
    input wire ready_busy_n_in
);
    localparam integer FULL_N = `FBI_CYC(`FBI_T_ADDR_NS) > `FBI_CYC(`FBI_T_SEL_NS) ?
        `FBI_CYC(`FBI_T_ADDR_NS) : `FBI_CYC(`FBI_T_SEL_NS);
    localparam integer PAGE_N = `FBI_CYC(`FBI_T_PAGE_NS);
    localparam integer SETUP_N = `FBI_CYC(`FBI_T_SETUP_NS);
    localparam integer WPULSE_N = `FBI_CYC(`FBI_T_WPULSE_NS);
    localparam integer RESET_N = `FBI_CYC(`FBI_T_RESET_NS);
    localparam integer RECOVER_N = `FBI_CYC(`FBI_T_RECOVER_NS);
    localparam [7:0] CYC_FULL = FULL_N[7:0];
    localparam [7:0] CYC_PAGE = PAGE_N[7:0];
    localparam [7:0] CYC_SETUP = SETUP_N[7:0];
    localparam [7:0] CYC_WPULSE = WPULSE_N[7:0];
    localparam [7:0] CYC_RESET = RESET_N[7:0];
    localparam [7:0] CYC_RECOVER = RECOVER_N[7:0];
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_READ = 3'h1;
    localparam [2:0] ST_WSETUP = 3'h2;
    localparam [2:0] ST_WPULSE = 3'h3;
    localparam [2:0] ST_WHOLD = 3'h4;
    localparam [2:0] ST_RESET = 3'h5;
    localparam [2:0] ST_RECOVER = 3'h6;

    function [2:0] bank_of;
        input dual;
        input [22:0] a;
        begin
            if (!dual) begin
                case (a[22:20]) // [R09]
                    3'h0: bank_of = `FBI_BANK_A;
                    3'h1, 3'h2, 3'h3: bank_of = `FBI_BANK_B;
                    3'h7: bank_of = `FBI_BANK_D;
                    default: bank_of = `FBI_BANK_C;
                endcase
            end else if (!a[22]) begin
                bank_of = (a[21:20] == 2'h3) ? `FBI_BANK_1B : `FBI_BANK_1A; // [R10]
            end else begin
                bank_of = (a[21:20] == 2'h0) ? `FBI_BANK_2A : `FBI_BANK_2B; // [R10]
            end
        end
    endfunction

    reg [2:0] state;
    reg [7:0] count;
    reg page_valid;
    reg [19:0] page_tag;
    reg [2:0] rb_sync;
    reg rb_level;
    reg cache_write;
    wire [15:0] cache_data;
    wire page_hit = page_valid && (page_tag == req_addr_in[22:3]);

    fbi_page_reg page_mem (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .write_in(cache_write),
        .word_in(addr_out[2:0]),
        .data_in(data_in),
        .read_word_in(req_addr_in[2:0]),
        .data_out(cache_data)
    );

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rb_sync <= 3'h7;
            rb_level <= 1'b1;
        end else begin
            rb_sync <= {rb_sync[1:0], ready_busy_n_in};
            if (rb_sync[2] == rb_sync[1]) begin
                rb_level <= rb_sync[2];
            end
        end
    end

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_RESET;
            count <= 8'h00;
            page_valid <= 1'b0;
            page_tag <= 20'h00000;
            cache_write <= 1'b0;
            req_ready_out <= 1'b0;
            resp_valid_out <= 1'b0;
            resp_data_out <= 16'h0000;
            resp_bank_out <= 3'h0;
            busy_seen_out <= 1'b0;
            addr_out <= 23'h000000;
            data_out <= 16'h0000;
            data_oe_out <= 1'b0;
            lower_half_select_n_out <= 1'b1;
            upper_half_select_n_out <= 1'b1;
            output_gate_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            hw_reset_n_out <= 1'b0;
            ram_select1_n_out <= 1'b1;
            ram_select2_out <= 1'b0;
            boost_high_out <= 1'b1;
            boost_fast_out <= 1'b0;
        end else begin
            resp_valid_out <= 1'b0;
            cache_write <= 1'b0;
            busy_seen_out <= ~rb_level; // [R21] [R23]
            ram_select1_n_out <= 1'b1; // [R17]
            ram_select2_out <= 1'b0; // [R17]
            boost_fast_out <= boost_fast_in; // [R14] [R15]
            boost_high_out <= boost_fast_in | ~boost_protect_in; // [R16]
            case (state)
                ST_IDLE: begin
                    if (req_valid_in && req_ready_out) begin
                        req_ready_out <= 1'b0;
                        addr_out <= req_addr_in;
                        resp_bank_out <= bank_of(dual_select_in, req_addr_in); // [R08]
                        if (req_op_in == `FBI_OP_RESET) begin
                            hw_reset_n_out <= 1'b0; // [R22]
                            lower_half_select_n_out <= 1'b1; // [R22]
                            upper_half_select_n_out <= 1'b1;
                            output_gate_n_out <= 1'b1;
                            data_oe_out <= 1'b0;
                            page_valid <= 1'b0;
                            count <= 8'h00;
                            state <= ST_RESET;
                        end else if (req_op_in == `FBI_OP_WRITE) begin
                            page_valid <= 1'b0; // [R04]
                            data_out <= req_data_in;
                            data_oe_out <= 1'b1;
                            output_gate_n_out <= 1'b1; // [R11]
                            lower_half_select_n_out <= dual_select_in & req_addr_in[22]; // [R02]
                            upper_half_select_n_out <= ~(dual_select_in & req_addr_in[22]);
                            count <= 8'h00;
                            state <= ST_WSETUP;
                        end else begin
                            write_strobe_n_out <= 1'b1; // [R01]
                            output_gate_n_out <= 1'b0; // [R01] [R18]
                            data_oe_out <= 1'b0;
                            lower_half_select_n_out <= dual_select_in & req_addr_in[22]; // [R02]
                            upper_half_select_n_out <= ~(dual_select_in & req_addr_in[22]);
                            count <= page_hit ? CYC_PAGE : CYC_FULL; // [R05] [R06]
                            page_tag <= req_addr_in[22:3]; // [R05]
                            state <= ST_READ;
                        end
                    end else begin
                        req_ready_out <= 1'b1;
                        if (!req_valid_in) begin
                            lower_half_select_n_out <= 1'b1; // [R19]
                            upper_half_select_n_out <= 1'b1;
                            output_gate_n_out <= 1'b1; // [R24]
                            page_valid <= 1'b0; // [R07] [R20]
                        end
                    end
                end
                ST_READ: begin
                    if (count <= 8'h01) begin
                        resp_data_out <= data_in;
                        cache_write <= 1'b1;
                        resp_valid_out <= 1'b1;
                        page_valid <= 1'b1; // [R03]
                        state <= ST_IDLE;
                    end else begin
                        count <= count - 8'h01;
                    end
                end
                ST_WSETUP: begin
                    if (count + 8'h01 >= CYC_SETUP) begin
                        write_strobe_n_out <= 1'b0; // [R25]
                        count <= 8'h00;
                        state <= ST_WPULSE;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                ST_WPULSE: begin
                    if (count + 8'h01 >= CYC_WPULSE) begin
                        write_strobe_n_out <= 1'b1; // [R25] [R12] [R13]
                        state <= ST_WHOLD;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                ST_WHOLD: begin
                    lower_half_select_n_out <= 1'b1;
                    upper_half_select_n_out <= 1'b1;
                    data_oe_out <= 1'b0;
                    resp_valid_out <= 1'b1;
                    state <= ST_IDLE;
                end
                ST_RESET: begin
                    hw_reset_n_out <= 1'b0;
                    if (count + 8'h01 >= CYC_RESET) begin
                        hw_reset_n_out <= 1'b1;
                        count <= 8'h00;
                        state <= ST_RECOVER;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                ST_RECOVER: begin
                    if (count + 8'h01 >= CYC_RECOVER && rb_level) begin // [R23]
                        resp_valid_out <= 1'b1;
                        state <= ST_IDLE;
                    end else if (count + 8'h01 < CYC_RECOVER) begin
                        count <= count + 8'h01;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // fbi_host
`default_nettype wire

// ### bench/fbi_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fbi_chk (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic resp_valid_out,
    input wire logic [22:0] addr_out,
    input wire logic data_oe_out,
    input wire logic dual_select_in,
    input wire logic lower_half_select_n_out,
    input wire logic upper_half_select_n_out,
    input wire logic output_gate_n_out,
    input wire logic write_strobe_n_out,
    input wire logic hw_reset_n_out,
    input wire logic ram_select1_n_out,
    input wire logic ram_select2_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    wire idle_n = lower_half_select_n_out && upper_half_select_n_out;
    property p_rd; !output_gate_n_out |-> write_strobe_n_out; endproperty
    a_rd: assert property (p_rd) else $error("strobe low in read");
    property p_wr; !write_strobe_n_out |-> output_gate_n_out && !idle_n; endproperty
    a_wr: assert property (p_wr) else $error("bad write cycle");
    property p_ram; ram_select1_n_out && !ram_select2_out; endproperty
    a_ram: assert property (p_ram) else $error("ram selected");
    property p_up;
        !upper_half_select_n_out |-> dual_select_in && addr_out[22] && lower_half_select_n_out;
    endproperty
    a_up: assert property (p_up) else $error("bad upper select");
    property p_lo; !lower_half_select_n_out |-> !dual_select_in || !addr_out[22]; endproperty
    a_lo: assert property (p_lo) else $error("bad lower select");
    property p_rst; !hw_reset_n_out |-> idle_n && output_gate_n_out && write_strobe_n_out; endproperty
    a_rst: assert property (p_rst) else $error("cycle during reset");
    property p_oe; data_oe_out |-> output_gate_n_out; endproperty
    a_oe: assert property (p_oe) else $error("bus contention");
    property p_full;
        $fell(output_gate_n_out) && $past(idle_n) |-> !resp_valid_out [*2];
    endproperty
    a_full: assert property (p_full) else $error("short first access");
    c_rd: cover property ($fell(output_gate_n_out));
    c_wr: cover property ($fell(write_strobe_n_out));
    c_rst: cover property ($fell(hw_reset_n_out));
endmodule // fbi_chk
bind fbi_host fbi_chk u_chk (.clock_in, .reset_in, .resp_valid_out, .addr_out, .data_oe_out,
    .dual_select_in, .lower_half_select_n_out, .upper_half_select_n_out, .output_gate_n_out,
    .write_strobe_n_out, .hw_reset_n_out, .ram_select1_n_out, .ram_select2_out);
`default_nettype wire

// ### bench/fbi_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbi_flash_model #(
    parameter logic [15:0] ID_CODE = 16'h1234 // Arbitrary value.
) (
    input wire logic [22:0] addr_in,
    input wire logic [15:0] dq_in,
    input wire logic lower_half_select_n_in,
    input wire logic upper_half_select_n_in,
    input wire logic output_gate_n_in,
    input wire logic write_strobe_n_in,
    input wire logic hw_reset_n_in,
    output logic [15:0] dq_out,
    output logic ready_busy_n_out
);
    logic id_mode = 1'b0;
    logic [15:0] last = 16'h0000;
    wire sel = !lower_half_select_n_in || !upper_half_select_n_in;
    wire drive = sel && !output_gate_n_in && hw_reset_n_in;
    wire [15:0] word = id_mode ? ID_CODE : addr_in[15:0] ^ 16'h5A5A;
    assign dq_out = drive ? word : ~last;
    initial ready_busy_n_out = 1'b1;
    always @(word or drive) if (drive) last = word;
    always @(posedge write_strobe_n_in) begin
        if (sel && hw_reset_n_in) begin
            if (dq_in == 16'h0090) id_mode = 1'b1;
            if (dq_in == 16'h00F0) id_mode = 1'b0;
            if (dq_in == 16'h0030) ready_busy_n_out = 1'b0;
        end
    end
    always @(negedge ready_busy_n_out) #3000 ready_busy_n_out = 1'b1;
    always @(negedge hw_reset_n_in) begin
        id_mode = 1'b0;
        #300 ready_busy_n_out = 1'b1;
    end
endmodule // fbi_flash_model
`default_nettype wire

// ### bench/flash_bank_bus_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbi_defs.vh"
module flash_bank_bus_interface_tb_top;
    logic clock_in = 1'b0, reset_in = 1'b1, req_valid_in = 1'b0, dual_select_in = 1'b0;
    logic boost_fast_in = 1'b0, boost_protect_in = 1'b0, req_ready_out, resp_valid_out;
    logic [1:0] req_op_in = 2'h0;
    logic [22:0] req_addr_in = 23'h000000, addr_out;
    logic [15:0] req_data_in = 16'h0000, resp_data_out, data_out, dq, data_in;
    logic [2:0] resp_bank_out;
    logic busy_seen_out, data_oe_out, lower_half_select_n_out, upper_half_select_n_out;
    logic output_gate_n_out, write_strobe_n_out, hw_reset_n_out, ram_select1_n_out;
    logic ram_select2_out, boost_high_out, boost_fast_out, ready_busy_n_in;
    int num_errors = 0, checks = 0, lat, first;
    assign data_in = data_oe_out ? data_out : dq;
    fbi_host dut (.clock_in, .reset_in, .req_valid_in, .req_op_in, .req_addr_in, .req_data_in,
        .dual_select_in, .boost_fast_in, .boost_protect_in, .req_ready_out, .resp_valid_out,
        .resp_data_out, .resp_bank_out, .busy_seen_out, .addr_out, .data_out, .data_oe_out,
        .data_in, .lower_half_select_n_out, .upper_half_select_n_out, .output_gate_n_out,
        .write_strobe_n_out, .hw_reset_n_out, .ram_select1_n_out, .ram_select2_out,
        .boost_high_out, .boost_fast_out, .ready_busy_n_in);
    fbi_flash_model fm (.addr_in(addr_out), .dq_in(data_in), .dq_out(dq),
        .lower_half_select_n_in(lower_half_select_n_out), .hw_reset_n_in(hw_reset_n_out),
        .upper_half_select_n_in(upper_half_select_n_out), .output_gate_n_in(output_gate_n_out),
        .write_strobe_n_in(write_strobe_n_out), .ready_busy_n_out(ready_busy_n_in));
    initial forever #25 clock_in = ~clock_in;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic req(input logic [1:0] op, input logic [22:0] a, input logic [15:0] d);
        int n;
        n = 0;
        // Raised at once so that an in-page read keeps the select low.
        {req_valid_in, req_op_in, req_addr_in, req_data_in} = {1'b1, op, a, d};
        while (req_ready_out !== 1'b1 && n < 400) begin
            @(posedge clock_in);
            #1 n++;
        end
        @(posedge clock_in);
        #1 req_valid_in = 1'b0;
        lat = 0;
        do begin
            @(posedge clock_in);
            #1 lat++;
        end while (resp_valid_out !== 1'b1 && lat < 400);
        if (n >= 400 || lat >= 400) chk(16'h0001, 16'h0000);
    endtask
    task automatic rd(input logic [22:0] a, input logic [15:0] exp);
        req(`FBI_OP_READ, a, 16'h0000);
        chk(resp_data_out, exp);
    endtask
    task automatic t_page;
        rd(23'h040010, 16'h0010 ^ 16'h5A5A);
        first = lat;
        for (int w = 1; w < 8; w++) begin
            rd(23'h040010 + w, (16'h0010 + w) ^ 16'h5A5A);
            chk({15'h0000, lat < first}, 16'h0001);
        end
        repeat (3) @(posedge clock_in);
        #1;
        rd(23'h040012, 16'h0012 ^ 16'h5A5A);
        chk(lat, first);
        $display("t_page done");
    endtask
    task automatic t_banks;
        logic [2:0] e;
        for (int d = 0; d < 2; d++) begin
            // The part variant only changes while both selects are high.
            repeat (2) @(posedge clock_in);
            #1 dual_select_in = d[0];
            for (int t = 0; t < 8; t++) begin
                req(`FBI_OP_READ, {t[2:0], 20'h00040}, 16'h0000);
                if (d == 0 && t == 0) e = `FBI_BANK_A;
                else if (d == 0 && t == 7) e = `FBI_BANK_D;
                else if (d == 0) e = t < 4 ? `FBI_BANK_B : `FBI_BANK_C;
                else if (t > 3) e = t == 4 ? `FBI_BANK_2A : `FBI_BANK_2B;
                else e = t == 3 ? `FBI_BANK_1B : `FBI_BANK_1A;
                chk(resp_bank_out, e);
            end
        end
        repeat (2) @(posedge clock_in);
        #1 dual_select_in = 1'b0;
        $display("t_banks done");
    endtask
    task automatic t_modes;
        req(`FBI_OP_WRITE, 23'h000555, 16'h0090);
        rd(23'h000000, 16'h1234);
        req(`FBI_OP_WRITE, 23'h000555, 16'h00F0);
        rd(23'h000003, 16'h0003 ^ 16'h5A5A);
        req(`FBI_OP_WRITE, 23'h000000, 16'h0030);
        rd(23'h700007, 16'h0007 ^ 16'h5A5A);
        chk(busy_seen_out, 1'b1);
        req(`FBI_OP_RESET, 23'h000000, 16'h0000);
        chk(busy_seen_out, 1'b0);
        rd(23'h000009, 16'h0009 ^ 16'h5A5A);
        $display("t_modes done");
    endtask
    task automatic t_boost;
        boost_protect_in = 1'b1;
        req(`FBI_OP_WRITE, 23'h000100, 16'h0000);
        chk(boost_high_out, 1'b0);
        {boost_protect_in, boost_fast_in} = 2'b01;
        req(`FBI_OP_WRITE, 23'h000100, 16'h0000);
        chk(boost_fast_out, 1'b1);
        boost_fast_in = 1'b0;
        req(`FBI_OP_WRITE, 23'h000100, 16'h0000);
        chk({boost_fast_out, boost_high_out}, 2'b01);
        $display("t_boost done");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock_in);
        #1 reset_in = 1'b0;
        t_page;
        t_banks;
        t_modes;
        t_boost;
        close_out;
    end
    initial begin
        #400000;
        num_errors++;
        close_out;
    end
endmodule // flash_bank_bus_interface_tb_top
`default_nettype wire
